// ===== inc/i2c_frame_pkg.sv
// Constants, state codes and the checksum function of the framed I2C register target.
// Assumes one core clock and a bus that is sampled, never used as a clock.
package i2c_frame_pkg;

  // Control word layout, first byte on the wire holds bits 23..16
  localparam int CW_DIR_BIT = 23;
  localparam int CW_CRC_BIT = 22;
  localparam int CW_LEN_LSB = 20;
  localparam int CW_SEC_LSB = 16;
  localparam int CW_PAGE_LSB = 12;
  localparam int CW_OFFSET_LSB = 0;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;

  // Payload length codes and byte counts
  localparam logic [1:0] LEN_16 = 2'h0;
  localparam logic [1:0] LEN_32 = 2'h1;
  localparam logic [1:0] LEN_64 = 2'h2;
  localparam logic [1:0] LEN_RSVD = 2'h3;
  localparam logic [3:0] BYTES_16 = 4'h2;
  localparam logic [3:0] BYTES_32 = 4'h4;
  localparam logic [3:0] BYTES_64 = 4'h8;
  localparam logic [3:0] BYTE_IDX_MAX = 4'hf;
  localparam logic [3:0] CTRL_LAST_IDX = 4'h2;

  // Second word of a 64-bit access sits this far above the first
  localparam logic [ADDR_W-1:0] WORD_STEP = 20'h0_0002;

  // Checksum: x^8+x^2+x+1, preset to all ones
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'hff;

  // Bit counter marks within one nine-clock byte slot
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_DONE = 4'h9;
  localparam logic [3:0] BIT_LAST = 4'h7;

  // Reset values
  localparam logic [23:0] CTRL_RST = 24'h00_0000;
  localparam logic [63:0] DATA_RST = 64'h0000_0000_0000_0000;

  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_ADDR    = 7'h02,
    ST_CTRL    = 7'h04,
    ST_WDATA   = 7'h08,
    ST_WAIT_RS = 7'h10,
    ST_RDATA   = 7'h20,
    ST_IGNORE  = 7'h40
  } xfer_state_e;

  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  function automatic logic [3:0] bytes_for(input logic [1:0] code);
    logic [3:0] n;
    n = BYTES_16;
    case (code)
      LEN_32: n = BYTES_32;
      LEN_64: n = BYTES_64;
      default: n = BYTES_16;
    endcase
    return n;
  endfunction

endpackage

// ===== src/i2c_framed_register_access.sv
// I2C target that carries framed register reads and writes with an optional checksum.
// Assumes SCL and SDA arrive asynchronously and are far slower than clk; the register
// side answers a read request before the last bit of the read address byte has been received.
module i2c_framed_register_access
  import i2c_frame_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [6:0] own_address,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [ADDR_W-1:0] wr_addr,
  output logic [DATA_W-1:0] wr_data,
  output logic rd_req,
  input wire logic rd_ack,
  output logic [ADDR_W-1:0] rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  output logic write_discarded,
  output logic busy
);

  localparam int ENTRY_W = ADDR_W + DATA_W;

  logic scl_m_r, scl_s_r, scl_q_r;
  logic sda_m_r, sda_s_r, sda_q_r;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  logic [3:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic sda_oe_r;
  logic byte_done, ack_rise, tx_active;
  logic [7:0] rx_byte;
  xfer_state_e state_r;
  logic [23:0] ctrl_r, ctrl_full;
  logic [3:0] byte_idx_r, tx_idx_r, tx_idx_nxt, nbytes;
  logic [63:0] data_r, rdata_r;
  logic [7:0] crc_r, rx_crc_r, tx_r;
  logic armed_r, ack_en_r, commit_r, discard_r, rd_start_r, busy_r;
  logic crc_en, write_ok, commit_busy;
  logic [ADDR_W-1:0] ctrl_addr;
  logic [1:0] stage_left_r;
  logic stage_sel_r, push, pop, fifo_ready;
  logic [ENTRY_W-1:0] stage_entry, slot0_r, slot1_r;
  logic v0_r, v1_r;
  logic rd_req_r, fetch_sel_r, fetch_two_r;
  logic [ADDR_W-1:0] rd_addr_r;

  //////////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and bus events

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_q_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_q_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_q_r <= sda_s_r;
    end
  end

  assign scl_rise = scl_s_r & ~scl_q_r;
  assign scl_fall = ~scl_s_r & scl_q_r;
  // SDA moving while SCL stays high is a start or a stop
  assign start_ev = scl_s_r & scl_q_r & sda_q_r & ~sda_s_r;
  assign stop_ev = scl_s_r & scl_q_r & ~sda_q_r & sda_s_r;

  //////////////////////////////////////////////////////////////////////////////////////
  // Bit engine: shifts bytes in, drives acknowledge and read data

  assign tx_active = (state_r == ST_RDATA);
  assign byte_done = scl_rise & (bit_cnt_r == BIT_LAST) & ~tx_active;
  assign ack_rise = scl_rise & (bit_cnt_r == BIT_ACK);
  assign rx_byte = {shift_r[6:0], sda_s_r};

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt_r <= 4'h0;
      shift_r <= 8'h00;
      sda_oe_r <= 1'b0;
    end else if (start_ev || stop_ev) begin
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (scl_rise) begin
      if (bit_cnt_r < BIT_ACK) begin
        shift_r <= rx_byte;
      end
      if (bit_cnt_r < BIT_DONE) begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end
    end else if (scl_fall) begin
      if (bit_cnt_r == BIT_ACK) begin
        // Acknowledge slot; during a read the controller owns it
        sda_oe_r <= ack_en_r;
      end else if (bit_cnt_r == BIT_DONE) begin
        bit_cnt_r <= 4'h0;
        sda_oe_r <= tx_active & ~tx_r[7];
      end else if (tx_active && bit_cnt_r != 4'h0) begin
        // Open drain: a zero bit pulls the line, a one releases it
        sda_oe_r <= ~tx_r[~bit_cnt_r[2:0]];
      end
    end
  end

  assign sda_oe = sda_oe_r;
  assign sda_out = 1'b0;

  //////////////////////////////////////////////////////////////////////////////////////
  // Transaction sequencer

  assign ctrl_full = {ctrl_r[15:0], rx_byte};
  assign crc_en = ctrl_r[CW_CRC_BIT];
  assign nbytes = bytes_for(ctrl_r[CW_LEN_LSB +: 2]);
  // Address is section, page and offset concatenated
  assign ctrl_addr = {ctrl_r[CW_SEC_LSB +: 4], ctrl_r[CW_PAGE_LSB +: 4],
                      ctrl_r[CW_OFFSET_LSB +: 12]};
  assign tx_idx_nxt = tx_idx_r + 4'h1;
  // Byte count must match exactly and, when the checksum is enabled, the checksum must agree
  assign write_ok = crc_en ? ((byte_idx_r == nbytes + 4'h1) && (rx_crc_r == crc_r))
                           : (byte_idx_r == nbytes);
  // A new write is refused while the previous one is still being staged into the two-entry buffer
  assign commit_busy = commit_r | (stage_left_r != 2'h0);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      ctrl_r <= CTRL_RST;
      byte_idx_r <= 4'h0;
      tx_idx_r <= 4'h0;
      data_r <= DATA_RST;
      crc_r <= CRC_INIT;
      rx_crc_r <= 8'h00;
      tx_r <= 8'hff;
      armed_r <= 1'b0;
      ack_en_r <= 1'b0;
      commit_r <= 1'b0;
      discard_r <= 1'b0;
      rd_start_r <= 1'b0;
    end else begin
      commit_r <= 1'b0;
      discard_r <= 1'b0;
      rd_start_r <= 1'b0;
      if (start_ev) begin
        // A read may follow either a repeated start or a stop then start
        armed_r <= (state_r == ST_WAIT_RS);
        state_r <= ST_ADDR;
        ack_en_r <= 1'b0;
      end else if (stop_ev) begin
        ack_en_r <= 1'b0;
        if (state_r == ST_WDATA) begin
          // Only a stop closes a write; an early start drops it
          commit_r <= write_ok;
          discard_r <= ~write_ok;
        end
        state_r <= (state_r == ST_WAIT_RS) ? ST_WAIT_RS : ST_IDLE;
      end else if (ack_rise) begin
        ack_en_r <= 1'b0;
        // Our own acknowledge of the read address must not advance the byte pointer
        if (state_r == ST_RDATA && !ack_en_r) begin
          if (sda_s_r) begin
            state_r <= ST_IGNORE;
          end else if (tx_idx_nxt < nbytes) begin
            tx_r <= rdata_r[{tx_idx_nxt[2:0], 3'h0} +: 8];
            crc_r <= crc8_byte(crc_r, rdata_r[{tx_idx_nxt[2:0], 3'h0} +: 8]);
            tx_idx_r <= tx_idx_nxt;
          end else if (tx_idx_nxt == nbytes && crc_en) begin
            tx_r <= crc_r;
            tx_idx_r <= tx_idx_nxt;
          end else begin
            state_r <= ST_IGNORE;
          end
        end
      end else if (byte_done) begin
        case (state_r)
          ST_ADDR: begin
            if (rx_byte[7:1] != own_address) begin
              state_r <= ST_IGNORE;
            end else if (!rx_byte[0]) begin
              if (commit_busy) begin
                state_r <= ST_IGNORE;
              end else begin
                ack_en_r <= 1'b1;
                state_r <= ST_CTRL;
                byte_idx_r <= 4'h0;
                crc_r <= crc8_byte(CRC_INIT, rx_byte);
              end
            end else if (armed_r) begin
              ack_en_r <= 1'b1;
              state_r <= ST_RDATA;
              tx_idx_r <= 4'h0;
              tx_r <= rdata_r[7:0];
              crc_r <= crc8_byte(crc8_byte(crc_r, rx_byte), rdata_r[7:0]);
            end else begin
              state_r <= ST_IGNORE;
            end
          end
          ST_CTRL: begin
            ctrl_r <= ctrl_full;
            crc_r <= crc8_byte(crc_r, rx_byte);
            byte_idx_r <= byte_idx_r + 4'h1;
            ack_en_r <= 1'b1;
            if (byte_idx_r == CTRL_LAST_IDX) begin
              byte_idx_r <= 4'h0;
              data_r <= DATA_RST;
              if (ctrl_full[CW_LEN_LSB +: 2] == LEN_RSVD) begin
                // Reserved length: refuse the last control byte
                ack_en_r <= 1'b0;
                state_r <= ST_IGNORE;
              end else if (ctrl_full[CW_DIR_BIT]) begin
                rd_start_r <= 1'b1;
                state_r <= ST_WAIT_RS;
              end else begin
                state_r <= ST_WDATA;
              end
            end
          end
          ST_WDATA: begin
            ack_en_r <= 1'b1;
            if (byte_idx_r != BYTE_IDX_MAX) begin
              byte_idx_r <= byte_idx_r + 4'h1;
            end
            if (byte_idx_r < nbytes) begin
              data_r[{byte_idx_r[2:0], 3'h0} +: 8] <= rx_byte;
              crc_r <= crc8_byte(crc_r, rx_byte);
            end else if (byte_idx_r == nbytes) begin
              rx_crc_r <= rx_byte;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (state_r != ST_IDLE) && (state_r != ST_IGNORE);
    end
  end

  assign busy = busy_r;
  assign write_discarded = discard_r;

  //////////////////////////////////////////////////////////////////////////////////////
  // Write staging: a committed frame becomes one or two word writes

  assign stage_entry = stage_sel_r ? {ctrl_addr + WORD_STEP, data_r[63:32]}
                                   : {ctrl_addr, data_r[31:0]};
  assign push = (stage_left_r != 2'h0) & fifo_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_left_r <= 2'h0;
      stage_sel_r <= 1'b0;
    end else if (commit_r) begin
      stage_left_r <= (ctrl_r[CW_LEN_LSB +: 2] == LEN_64) ? 2'h2 : 2'h1;
      stage_sel_r <= 1'b0;
    end else if (push) begin
      stage_left_r <= stage_left_r - 2'h1;
      stage_sel_r <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer toward the register side

  assign fifo_ready = ~v1_r;
  assign pop = v0_r & wr_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      slot0_r <= '0;
      slot1_r <= '0;
    end else begin
      case ({push, pop})
        2'b10: begin
          if (!v0_r) begin
            slot0_r <= stage_entry;
            v0_r <= 1'b1;
          end else begin
            slot1_r <= stage_entry;
            v1_r <= 1'b1;
          end
        end
        2'b01: begin
          slot0_r <= slot1_r;
          v0_r <= v1_r;
          v1_r <= 1'b0;
        end
        2'b11: begin
          if (v1_r) begin
            slot0_r <= slot1_r;
            slot1_r <= stage_entry;
          end else begin
            slot0_r <= stage_entry;
          end
        end
        default: begin
        end
      endcase
    end
  end

  assign wr_valid = v0_r;
  assign wr_addr = slot0_r[ENTRY_W-1:DATA_W];
  assign wr_data = slot0_r[DATA_W-1:0];

  //////////////////////////////////////////////////////////////////////////////////////
  // Read prefetch: words are fetched as soon as the control word is in,
  // because the bus is not stretched while waiting for them

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_req_r <= 1'b0;
      rd_addr_r <= '0;
      fetch_sel_r <= 1'b0;
      fetch_two_r <= 1'b0;
      rdata_r <= DATA_RST;
    end else if (rd_start_r) begin
      rd_req_r <= 1'b1;
      rd_addr_r <= ctrl_addr;
      fetch_sel_r <= 1'b0;
      fetch_two_r <= (ctrl_r[CW_LEN_LSB +: 2] == LEN_64);
      rdata_r <= DATA_RST;
    end else if (rd_req_r && rd_ack) begin
      if (fetch_sel_r) begin
        rdata_r[63:32] <= rd_data;
      end else begin
        rdata_r[31:0] <= rd_data;
      end
      if (!fetch_sel_r && fetch_two_r) begin
        fetch_sel_r <= 1'b1;
        rd_addr_r <= rd_addr_r + WORD_STEP;
      end else begin
        rd_req_r <= 1'b0;
      end
    end
  end

  assign rd_req = rd_req_r;
  assign rd_addr = rd_addr_r;

endmodule

// ===== verification/i2c_frame_assertions.sv
// Port checker for the framed I2C register target.
// Assumes bus pins are sampled by clk; bound from the bench top file.
module i2c_frame_checker
  import i2c_frame_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic rd_req,
  input wire logic rd_ack,
  input wire logic [ADDR_W-1:0] rd_addr,
  input wire logic write_discarded,
  input wire logic busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  sda_zero_a: assert property (sda_out == 1'b0)
    else $error("data pin value not zero");
  // A change while SCL is high would look like a start or stop
  sda_timing_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line moved while clock high");
  wr_hold_a: assert property (wr_valid && !wr_ready |=>
    wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("write word dropped before taken");
  rd_hold_a: assert property (rd_req && !rd_ack |=> rd_req && $stable(rd_addr))
    else $error("read request dropped before answer");
  rd_step_a: assert property ($past(rd_req) && rd_req && $changed(rd_addr) |->
    rd_addr == $past(rd_addr) + WORD_STEP)
    else $error("second read word not at address plus two");
  disc_pulse_a: assert property (write_discarded |=> !write_discarded)
    else $error("discard flag longer than one cycle");
  rd_start_a: assert property ($rose(rd_req) |-> busy)
    else $error("read fetch outside a transaction");
  commit_idle_a: assert property ($rose(wr_valid) |-> !busy)
    else $error("write committed before frame ended");
endmodule

// ===== verification/i2c_ctl_model.sv
// Behavioural I2C controller: drives SCL and an open-drain pull on SDA.
// Assumes the bench resolves SDA with a pull-up; changes only at clk falls.
module i2c_ctl_model (
  input wire logic clk,
  output logic scl,
  output logic pull,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock rests high between frames, 20 clk per bit gives 160 ns
  initial begin
    scl = 1'b1;
    pull = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Works from idle or from a low clock, so it serves as repeated start too
  task automatic start();
    pull = 1'b0;
    hold(5);
    scl = 1'b1;
    hold(10);
    pull = 1'b1;
    hold(10);
    scl = 1'b0;
    hold(5);
  endtask
  task automatic stop();
    pull = 1'b1;
    hold(5);
    scl = 1'b1;
    hold(10);
    pull = 1'b0;
    hold(20);
  endtask
  task automatic bit_x(input logic b, output logic r);
    pull = !b;
    hold(5);
    scl = 1'b1;
    hold(5);
    r = sda;
    hold(5);
    scl = 1'b0;
    hold(5);
  endtask
  // Eight bits MSB first, then the ninth bit in either direction
  task automatic xfer(input logic [7:0] d, input logic a_in, output logic [7:0] r,
                      output logic a_out);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(a_in, a_out);
  endtask
endmodule

// ===== verification/tb_i2c_framed_register_access.sv
// Self-checking bench: controller model on the bus, register side modelled here.
// Assumes the package constants and a 125 MHz core clock.
module tb_i2c_framed_register_access;
  timeunit 1ns;
  timeprecision 1ps;
  import i2c_frame_pkg::*;
  logic clk, rst, scl, pull, sda_oe, sda_out, wr_valid, wr_ready, rd_req, rd_ack;
  logic write_discarded, busy, hold_wr;
  logic [ADDR_W-1:0] wr_addr, rd_addr;
  logic [DATA_W-1:0] wr_data, rd_data;
  logic [6:0] own_address;
  logic [15:0] lfsr_r;
  logic [7:0] crc_r;
  logic [51:0] popq[$];
  int n_fail, comparisons, n_disc, exp_disc;
  wire sda = !(sda_oe | pull);
  i2c_framed_register_access dut_u (.clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .own_address(own_address), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req),
    .rd_ack(rd_ack), .rd_addr(rd_addr), .rd_data(rd_data),
    .write_discarded(write_discarded), .busy(busy));
  i2c_ctl_model ctl_u (.clk(clk), .scl(scl), .pull(pull), .sda(sda));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    logic [31:0] v;
    for (int i = 0; i < 32; i++) begin
      lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      v = {v[30:0], lfsr_r[0]};
    end
    return v;
  endfunction
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
    c = c ^ b;
    for (int i = 0; i < 8; i++) c = {c[6:0], 1'b0} ^ (c[7] ? 8'h07 : 8'h00);
    return c;
  endfunction
  function automatic logic [31:0] mem_word(input logic [19:0] a);
    return {~a[15:0], a[15:0]};
  endfunction
  ////////////////////////////////////////////////////////////
  // Register side: random stalls on both ports, never two read acks in a row
  always @(negedge clk) begin
    logic [31:0] r;
    r = rnd();
    wr_ready <= !hold_wr & r[0];
    rd_ack <= rd_req & !rd_ack & r[1];
    rd_data <= mem_word(rd_addr);
  end
  always @(posedge clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) popq.push_back({wr_addr, wr_data});
    if (write_discarded === 1'b1) n_disc++;
  end
  task automatic stop_test();
    $display("Failures %0d of %0d comparisons", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [51:0] got, input logic [51:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic put(input logic [7:0] b, input logic ack);
    logic [7:0] r;
    logic a;
    ctl_u.xfer(b, 1'b1, r, a);
    crc_r = crc8(crc_r, b);
    chk(a, !ack, "ack");
  endtask
  task automatic head(input logic [23:0] cw, input logic last);
    crc_r = 8'hff;
    ctl_u.start();
    put({own_address, 1'b0}, 1'b1);
    put(cw[23:16], 1'b1);
    put(cw[15:8], 1'b1);
    put(cw[7:0], last);
  endtask
  task automatic refused(input logic [6:0] ad);
    ctl_u.start();
    put({ad, 1'b0}, 1'b0);
    put(8'h00, 1'b0);
    ctl_u.stop();
  endtask
  task automatic wr_frame(input logic [23:0] cw, input logic [63:0] d, input int extra,
                          input logic bad);
    head(cw, 1'b1);
    for (int i = 0; i < (2 << cw[21:20]) + extra; i++) begin
      put(d[8*(i%8) +: 8], 1'b1);
    end
    if (cw[CW_CRC_BIT]) put(crc_r ^ {7'h00, bad}, 1'b1);
    ctl_u.stop();
  endtask
  task automatic check_pops(input logic [23:0] cw, input logic [63:0] d, input int k);
    for (int t = 0; t < 200 && popq.size() < k; t++) @(negedge clk);
    chk(popq.size(), k, "pops");
    chk(n_disc, exp_disc, "discards");
    if (popq.size() != k) stop_test();
    if (k > 0) chk(popq.pop_front(), {cw[19:0], cw[21:20] == LEN_16 ?
      {16'h0000, d[15:0]} : d[31:0]}, "word");
    if (k > 1) chk(popq.pop_front(), {cw[19:0] + WORD_STEP, d[63:32]}, "word2");
  endtask
  task automatic rd_frame(input logic [23:0] cw, input logic ps);
    logic [7:0] r;
    logic a;
    logic [63:0] w;
    w = {mem_word(cw[19:0] + WORD_STEP), mem_word(cw[19:0])};
    head(cw, 1'b1);
    if (ps) ctl_u.stop();
    ctl_u.start();
    put({own_address, 1'b1}, 1'b1);
    for (int i = 0; i < (2 << cw[21:20]) + cw[22]; i++) begin
      ctl_u.xfer(8'hff, 1'b0, r, a);
      chk(r, i < (2 << cw[21:20]) ? w[8*i +: 8] : crc_r, "rdata");
      crc_r = crc8(crc_r, w[8*i +: 8]);
    end
    ctl_u.stop();
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    stop_test();
  end
  initial begin
    logic [23:0] cw, cw2;
    logic [63:0] d, d2;
    rst = 1'b1;
    hold_wr = 1'b0;
    wr_ready = 1'b0;
    rd_ack = 1'b0;
    rd_data = 32'h0000_0000;
    own_address = 7'h3a;
    lfsr_r = 16'h000d;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (5) @(negedge clk);
    for (int i = 0; i < 6; i++) begin
      // Only the low 20 random bits form the address; the top nibble is built by hand
      cw = {1'b0, i[0], i[2:1], 20'(rnd())};
      d = {rnd(), rnd()};
      wr_frame(cw, d, 0, 1'b0);
      check_pops(cw, d, i > 3 ? 2 : 1);
      cw = {1'b1, i[0], 2'(i % 3), 20'(rnd())};
      rd_frame(cw, i < 3);
    end
    refused(own_address ^ 7'h01);
    check_pops(cw, d, 0);
    exp_disc = exp_disc + 1;
    wr_frame(24'h50_0080, d, 0, 1'b1);
    check_pops(cw, d, 0);
    exp_disc = exp_disc + 2;
    wr_frame(24'h10_0100, d, 1, 1'b0);
    wr_frame(24'h10_0100, d, -1, 1'b0);
    check_pops(cw, d, 0);
    head(24'h10_0200, 1'b1);
    put(d[7:0], 1'b1);
    ctl_u.start();
    ctl_u.stop();
    check_pops(cw, d, 0);
    head(24'h30_0000, 1'b0);
    ctl_u.stop();
    hold_wr = 1'b1;
    cw = 24'h20_0080;
    cw2 = 24'h10_0400;
    d2 = {rnd(), rnd()};
    wr_frame(cw, d, 0, 1'b0);
    wr_frame(cw2, d2, 0, 1'b0);
    refused(own_address);
    hold_wr = 1'b0;
    check_pops(cw, d, 3);
    check_pops(cw2, d2, 1);
    stop_test();
  end
endmodule
bind i2c_framed_register_access i2c_frame_checker chk_u (.clk(clk), .rst(rst),
  .scl_in(scl_in), .sda_out(sda_out), .sda_oe(sda_oe), .wr_valid(wr_valid),
  .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data), .rd_req(rd_req),
  .rd_ack(rd_ack), .rd_addr(rd_addr), .write_discarded(write_discarded), .busy(busy));
